// ---- rtl/keypad_menu_navigator.sv ----
// Keypad command interpreter with menu navigation, display fields and APB registers
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Operation
// - Escape at level 1 returns to monitoring.
// - Escape at level 2 returns to group selection level 1.
// - Escape at level 3 drops the edit, parameter unchanged, back to level 2.
// - Up key in monitoring raises the speed reference.
// - Up: previous group, next parameter, or increment value by level.
// - Down: next group, previous parameter, or decrement value by level.
// - Direction key reverses only if active direction source is 2 or 3.
// - Local/remote key toggles only if selection setting is 2 or 3.
// - Enter advances: monitoring to level 1, to level 2, to level 3.
// - Enter at level 3 stores the edited value and returns to level 2.
// - Run key starts motor only if active run/stop source is 0.
// - Stop key stops motor under the same source condition as run.
// - Held jog ramps to jog speed; needs stopped, enabled, jog source 1.
// - Focus shows parameter number at level 2, value at level 3.
// - Monitoring shows two selected variables, main and secondary.
// - Fault code in main blocks navigation until escape, then secondary.
// - Alarm code in main blocks navigation until any key, then secondary.
// - Status field shows source, direction, config, undervoltage, running.
// - Level 1 cycles through ten parameter groups.
// - Config-only parameters store only when stopped; read-only never store.
module keypad_menu_navigator
    import keypad_menu_pkg::*;
#(
    parameter int ALL_PARAMETERS_GROUP_N = 16,
    parameter int PIDX_W = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Keypad pins, high while pressed
    input wire logic key_escape,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_enter,
    input wire logic key_dir,
    input wire logic key_locrem,
    input wire logic key_run,
    input wire logic key_stop,
    input wire logic key_jog,
    // Display fields
    output logic [15:0] main_field,
    output show_t main_show,
    output logic [15:0] sec_field,
    output show_t sec_show,
    output logic [3:0] menu_group,
    output logic focus_value,
    // Status indicators
    output logic local_source_indicator,
    output logic remote_source_indicator,
    output logic fwd_arrow,
    output logic rev_arrow,
    output logic config_state_indicator,
    output logic undervoltage_indicator,
    output logic running_indicator,
    // Motor commands
    output logic run_cmd,
    output logic reverse_cmd,
    output logic jog_cmd,
    output logic [15:0] speed_ref,
    output logic [15:0] jog_speed
);

    // Key synchroniser: three stages, level accepted when stages 2 and 3 agree
    logic [KEY_N-1:0] key_raw;
    logic [KEY_N-1:0] ks1_q, ks2_q, ks3_q, key_q, key_d, press;
    assign key_raw = {key_jog, key_stop, key_run, key_locrem, key_dir,
                      key_enter, key_down, key_up, key_escape};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ks1_q <= '0;
            ks2_q <= '0;
            ks3_q <= '0;
        end else begin
            ks1_q <= key_raw;
            ks2_q <= ks1_q;
            ks3_q <= ks2_q;
        end
    end

    always_comb begin
        for (int i = 0; i < KEY_N; i++) begin
            key_d[i] = (ks2_q[i] == ks3_q[i]) ? ks3_q[i] : key_q[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_q <= '0;
        end else begin
            key_q <= key_d;
        end
    end

    assign press = key_d & ~key_q;

    // Software-visible registers
    logic [31:0] ctrl_q, limit_q, mon_q, fault_q, alarm_q;
    logic [15:0] jog_q, speed_q;
    logic [17:0] ptab_q [ALL_PARAMETERS_GROUP_N];
    logic [31:0] prdata_q;
    logic wr_en, rd_setup, addr_ok, in_tab;
    logic [PIDX_W-1:0] tab_idx;

    assign in_tab = paddr >= PTAB_OFS && paddr < PTAB_OFS + 8'(4 * ALL_PARAMETERS_GROUP_N)
                    && paddr[1:0] == 2'b00;
    assign tab_idx = PIDX_W'((paddr - PTAB_OFS) >> 2);
    assign addr_ok = in_tab || paddr == CTRL_OFS || paddr == JOG_OFS
                     || paddr == LIMIT_OFS || paddr == MON_OFS || paddr == FAULT_OFS
                     || paddr == ALARM_OFS || paddr == SPEED_OFS || paddr == STATUS_OFS;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    // Zero wait states: read data captured in the setup cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = prdata_q;

    // Menu state
    menu_state_t state_q;
    logic [3:0] group_q;
    logic [PIDX_W-1:0] pidx_q;
    logic [15:0] edit_q;
    logic run_q, rev_q, remote_q, jog_q2;
    logic fault_blk_q, alarm_blk_q, fault_prev_q, alarm_prev_q;
    logic fault_on, alarm_on, blocked, any_press, stopped;
    logic store_ok;
    logic [15:0] lim_min, lim_max;
    logic [1:0] dir_src, runstop_src, jog_src;

    assign fault_on = fault_q[ACTIVE_POS];
    assign alarm_on = alarm_q[ACTIVE_POS];
    assign any_press = |press;
    assign blocked = fault_blk_q || alarm_blk_q;
    assign lim_min = limit_q[15:0];
    assign lim_max = limit_q[31:16];
    assign stopped = !run_q && !jog_q2;
    assign dir_src = remote_q ? ctrl_q[RDIR_POS +: 2] : ctrl_q[LDIR_POS +: 2];
    assign runstop_src = remote_q ? ctrl_q[RRUN_POS +: 2] : ctrl_q[LRUN_POS +: 2];
    assign jog_src = remote_q ? ctrl_q[RJOG_POS +: 2] : ctrl_q[LJOG_POS +: 2];
    assign store_ok = !ptab_q[pidx_q][RO_POS] && (!ptab_q[pidx_q][CFG_POS] || stopped);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            jog_q <= JOG_RST;
            limit_q <= LIMIT_RST;
            mon_q <= '0;
            fault_q <= '0;
            alarm_q <= '0;
        end else if (wr_en) begin
            case (paddr)
                CTRL_OFS: ctrl_q <= pwdata;
                JOG_OFS: jog_q <= pwdata[15:0];
                LIMIT_OFS: limit_q <= pwdata;
                MON_OFS: mon_q <= pwdata;
                FAULT_OFS: fault_q <= {15'h0000, pwdata[16:0]};
                ALARM_OFS: alarm_q <= {15'h0000, pwdata[16:0]};
                default: ;
            endcase
        end
    end

    // Parameter table; a keypad store wins over a same-cycle bus write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ALL_PARAMETERS_GROUP_N; i++) begin
                ptab_q[i] <= '0;
            end
        end else if (state_q == ST_LVL3 && press[K_ENTER] && !blocked && store_ok) begin
            ptab_q[pidx_q][15:0] <= edit_q;
        end else if (wr_en && in_tab) begin
            ptab_q[tab_idx] <= pwdata[17:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            prdata_q <= '0;
            if (in_tab) begin
                prdata_q <= {14'h0000, ptab_q[tab_idx]};
            end
            case (paddr)
                CTRL_OFS: prdata_q <= ctrl_q;
                JOG_OFS: prdata_q <= {16'h0000, jog_q};
                LIMIT_OFS: prdata_q <= limit_q;
                MON_OFS: prdata_q <= mon_q;
                FAULT_OFS: prdata_q <= fault_q;
                ALARM_OFS: prdata_q <= alarm_q;
                SPEED_OFS: prdata_q <= {16'h0000, speed_q};
                STATUS_OFS: prdata_q <= {16'h0000, 4'(pidx_q), group_q,
                                         fault_blk_q, alarm_blk_q, jog_q2, remote_q,
                                         rev_q, run_q, 2'(state_q)};
                default: ;
            endcase
        end
    end

    // Fault and alarm takeover; the entry edge wins over a same-cycle release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_prev_q <= 1'b0;
            alarm_prev_q <= 1'b0;
            fault_blk_q <= 1'b0;
            alarm_blk_q <= 1'b0;
        end else begin
            fault_prev_q <= fault_on;
            alarm_prev_q <= alarm_on;
            if (fault_on && !fault_prev_q) begin
                fault_blk_q <= 1'b1;
            end else if (press[K_ESC] || !fault_on) begin
                fault_blk_q <= 1'b0;
            end
            if (alarm_on && !alarm_prev_q) begin
                alarm_blk_q <= 1'b1;
            end else if ((any_press && !fault_blk_q) || !alarm_on) begin
                alarm_blk_q <= 1'b0;
            end
        end
    end

    // Menu navigation; keys releasing a fault or alarm are consumed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_MON;
            group_q <= '0;
            pidx_q <= '0;
            edit_q <= '0;
        end else if (!blocked) begin
            case (state_q)
                ST_MON: begin
                    if (press[K_ENTER]) begin
                        state_q <= ST_LVL1;
                    end
                end
                ST_LVL1: begin
                    if (press[K_ESC]) begin
                        state_q <= ST_MON;
                    end else if (press[K_ENTER]) begin
                        state_q <= ST_LVL2;
                        pidx_q <= '0;
                    // Previous group, ten in a ring
                    end else if (press[K_UP]) begin
                        group_q <= (group_q == 4'h0) ? GROUP_LAST : group_q - 4'h1;
                    end else if (press[K_DOWN]) begin
                        group_q <= (group_q == GROUP_LAST) ? 4'h0 : group_q + 4'h1;
                    end
                end
                ST_LVL2: begin
                    if (press[K_ESC]) begin
                        state_q <= ST_LVL1;
                    end else if (press[K_ENTER]) begin
                        state_q <= ST_LVL3;
                        edit_q <= ptab_q[pidx_q][15:0];
                    end else if (press[K_UP]) begin
                        pidx_q <= pidx_q + 1'b1;
                    end else if (press[K_DOWN]) begin
                        pidx_q <= pidx_q - 1'b1;
                    end
                end
                ST_LVL3: begin
                    if (press[K_ESC]) begin
                        state_q <= ST_LVL2;
                    // Back to level 2 after store
                    end else if (press[K_ENTER]) begin
                        state_q <= ST_LVL2;
                    end else if (press[K_UP]) begin
                        edit_q <= (edit_q >= lim_max) ? lim_max : edit_q + 16'h0001;
                    end else if (press[K_DOWN]) begin
                        edit_q <= (edit_q <= lim_min) ? lim_min : edit_q - 16'h0001;
                    end
                end
                default: state_q <= ST_MON;
            endcase
        end
    end

    // Speed reference; software may preset it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_q <= SPEED_RST;
        end else if (state_q == ST_MON && !blocked && press[K_UP]) begin
            speed_q <= (speed_q == SPEED_MAX) ? SPEED_MAX : speed_q + 16'h0001;
        end else if (wr_en && paddr == SPEED_OFS) begin
            speed_q <= pwdata[15:0];
        end
    end

    // Motor command keys act in every menu state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            rev_q <= 1'b0;
            remote_q <= 1'b0;
            jog_q2 <= 1'b0;
        end else begin
            if (press[K_RUN] && runstop_src == 2'd0 && ctrl_q[GEN_EN_POS]) begin
                run_q <= 1'b1;
            end else if (press[K_STOP] && runstop_src == 2'd0) begin
                run_q <= 1'b0;
            end
            // Disable drops the run command at once
            if (!ctrl_q[GEN_EN_POS]) begin
                run_q <= 1'b0;
            end
            if (press[K_DIR] && (dir_src == 2'd2 || dir_src == 2'd3)) begin
                rev_q <= !rev_q;
            end
            if (press[K_LOCREM] && (ctrl_q[LREM_POS +: 2] == 2'd2
                                    || ctrl_q[LREM_POS +: 2] == 2'd3)) begin
                remote_q <= !remote_q;
            end
            // Jog while held, ends on release
            if (!key_d[K_JOG] || !ctrl_q[GEN_EN_POS]) begin
                jog_q2 <= 1'b0;
            end else if (press[K_JOG] && !run_q && jog_src == 2'd1) begin
                jog_q2 <= 1'b1;
            end
        end
    end

    // Display composition
    logic [15:0] main_d, sec_d;
    show_t main_show_d, sec_show_d;

    always_comb begin
        main_d = mon_q[15:0];
        main_show_d = SHOW_VAR;
        sec_d = mon_q[31:16];
        sec_show_d = SHOW_VAR;
        case (state_q)
            ST_MON: ;
            ST_LVL1: begin
                main_d = {12'h000, group_q};
                main_show_d = SHOW_GROUP;
            end
            // Number in focus at level 2
            ST_LVL2: begin
                main_d = 16'(pidx_q);
                main_show_d = SHOW_PNUM;
                sec_d = ptab_q[pidx_q][15:0];
                sec_show_d = SHOW_PVAL;
            end
            // Value in focus at level 3
            ST_LVL3: begin
                main_d = edit_q;
                main_show_d = SHOW_PVAL;
                sec_d = 16'(pidx_q);
                sec_show_d = SHOW_PNUM;
            end
            default: ;
        endcase
        if (alarm_on) begin
            if (alarm_blk_q) begin
                main_d = alarm_q[15:0];
                main_show_d = SHOW_ALARM;
            end else begin
                sec_d = alarm_q[15:0];
                sec_show_d = SHOW_ALARM;
            end
        end
        if (fault_on) begin
            if (fault_blk_q) begin
                main_d = fault_q[15:0];
                main_show_d = SHOW_FAULT;
            end else begin
                sec_d = fault_q[15:0];
                sec_show_d = SHOW_FAULT;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_field <= '0;
            main_show <= SHOW_VAR;
            sec_field <= '0;
            sec_show <= SHOW_VAR;
            menu_group <= '0;
            focus_value <= 1'b0;
        end else begin
            main_field <= main_d;
            main_show <= main_show_d;
            sec_field <= sec_d;
            sec_show <= sec_show_d;
            menu_group <= group_q;
            focus_value <= state_q == ST_LVL3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            local_source_indicator <= 1'b0;
            remote_source_indicator <= 1'b0;
            fwd_arrow <= 1'b0;
            rev_arrow <= 1'b0;
            config_state_indicator <= 1'b0;
            undervoltage_indicator <= 1'b0;
            running_indicator <= 1'b0;
        end else begin
            local_source_indicator <= !remote_q;
            remote_source_indicator <= remote_q;
            fwd_arrow <= !rev_q;
            rev_arrow <= rev_q;
            config_state_indicator <= ctrl_q[CONFIG_POS];
            undervoltage_indicator <= ctrl_q[UNDERV_POS];
            running_indicator <= !stopped;
        end
    end

    assign run_cmd = run_q;
    assign reverse_cmd = rev_q;
    assign jog_cmd = jog_q2;
    assign speed_ref = speed_q;
    assign jog_speed = jog_q;

endmodule : keypad_menu_navigator

// ---- rtl/keypad_menu_pkg.sv ----
// Shared constants and types for the keypad menu navigator
package keypad_menu_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] JOG_OFS = 8'h04;
    localparam logic [7:0] LIMIT_OFS = 8'h08;
    localparam logic [7:0] MON_OFS = 8'h0C;
    localparam logic [7:0] FAULT_OFS = 8'h10;
    localparam logic [7:0] ALARM_OFS = 8'h14;
    localparam logic [7:0] SPEED_OFS = 8'h18;
    localparam logic [7:0] STATUS_OFS = 8'h1C;
    localparam logic [7:0] PTAB_OFS = 8'h40;
    // Control register fields, two bits per source setting
    localparam int LDIR_POS = 0;
    localparam int RDIR_POS = 2;
    localparam int LREM_POS = 4;
    localparam int LRUN_POS = 6;
    localparam int RRUN_POS = 8;
    localparam int LJOG_POS = 10;
    localparam int RJOG_POS = 12;
    localparam int GEN_EN_POS = 16;
    localparam int UNDERV_POS = 17;
    localparam int CONFIG_POS = 18;
    // Code and table fields
    localparam int ACTIVE_POS = 16;
    localparam int RO_POS = 16;
    localparam int CFG_POS = 17;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0001_142A;
    localparam logic [15:0] JOG_RST = 16'h0100;
    localparam logic [31:0] LIMIT_RST = 32'hFFFF_0000;
    localparam logic [15:0] SPEED_RST = 16'h0000;
    localparam logic [15:0] SPEED_MAX = 16'hFFFF;
    localparam logic [3:0] GROUP_LAST = 4'h9;
    // Key indices
    localparam int KEY_N = 9;
    localparam int K_ESC = 0;
    localparam int K_UP = 1;
    localparam int K_DOWN = 2;
    localparam int K_ENTER = 3;
    localparam int K_DIR = 4;
    localparam int K_LOCREM = 5;
    localparam int K_RUN = 6;
    localparam int K_STOP = 7;
    localparam int K_JOG = 8;
    typedef enum logic [1:0] {ST_MON, ST_LVL1, ST_LVL2, ST_LVL3} menu_state_t;
    typedef enum logic [2:0] {
        SHOW_VAR, SHOW_GROUP, SHOW_PNUM, SHOW_PVAL, SHOW_FAULT, SHOW_ALARM
    } show_t;
endpackage : keypad_menu_pkg

// ---- verification/keypad_menu_checker.sv ----
// Port-level assertions for the keypad menu navigator
`timescale 1ns/1ps
module keypad_menu_checker
    import keypad_menu_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Keys
    input wire logic key_escape,
    input wire logic key_enter,
    input wire logic key_jog,
    // Display and status
    input wire show_t main_show,
    input wire logic [3:0] menu_group,
    input wire logic focus_value,
    input wire logic local_source_indicator,
    input wire logic remote_source_indicator,
    input wire logic fwd_arrow,
    input wire logic rev_arrow,
    input wire logic running_indicator,
    // Motor commands
    input wire logic run_cmd,
    input wire logic jog_cmd
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Long enough to pass the key synchroniser
    sequence held_s(k);
        $rose(k) ##1 k [*3];
    endsequence
    enter_opens_a: assert property ((main_show == SHOW_VAR) ##0 held_s(key_enter)
        |-> ##[0:4] main_show == SHOW_GROUP) else $error("enter did not open groups");
    escape_top_a: assert property ((main_show == SHOW_GROUP) ##0 held_s(key_escape)
        |-> ##[0:4] main_show == SHOW_VAR) else $error("escape did not leave groups");
    source_excl_a: assert property (
        !(local_source_indicator && remote_source_indicator))
        else $error("both source indicators lit");
    arrow_excl_a: assert property (!(fwd_arrow && rev_arrow))
        else $error("both arrows lit");
    run_shown_a: assert property (run_cmd [*2] |-> running_indicator)
        else $error("running indicator off while running");
    group_range_a: assert property (menu_group <= GROUP_LAST)
        else $error("group beyond last");
    fault_lock_a: assert property (main_show == SHOW_FAULT
        |=> $stable(menu_group) && $stable(focus_value)) else $error("moved under fault");
    alarm_lock_a: assert property (main_show == SHOW_ALARM
        |=> $stable(menu_group) && $stable(focus_value)) else $error("moved under alarm");
    jog_start_a: assert property ($rose(jog_cmd) |-> !$past(run_cmd))
        else $error("jog started while running");
    jog_stop_a: assert property (!key_jog [*6] |-> !jog_cmd)
        else $error("jog kept after release");
endmodule : keypad_menu_checker

bind keypad_menu_navigator keypad_menu_checker chk_u (
    .pclk, .presetn, .key_escape, .key_enter, .key_jog, .main_show, .menu_group,
    .focus_value, .local_source_indicator, .remote_source_indicator, .fwd_arrow,
    .rev_arrow, .running_indicator, .run_cmd, .jog_cmd
);

// ---- verification/keypad_menu_navigator_test.sv ----
// Self-checking bench for the keypad menu navigator
`timescale 1ns/1ps
module keypad_menu_navigator_test
    import keypad_menu_pkg::*;
();
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, serr, focus_value, run_cmd, reverse_cmd, jog_cmd;
    logic local_source_indicator, remote_source_indicator, fwd_arrow, rev_arrow;
    logic config_state_indicator, undervoltage_indicator, running_indicator;
    logic [KEY_N-1:0] keys;
    logic [15:0] main_field, sec_field, speed_ref, jog_speed;
    logic [3:0] menu_group;
    show_t main_show, sec_show;
    int mismatches = 0;
    int checked = 0;
    always #25 pclk = ~pclk;
    keypad_operator op_u (.pclk, .keys);
    keypad_menu_navigator dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .key_escape(keys[K_ESC]), .key_up(keys[K_UP]), .key_down(keys[K_DOWN]),
        .key_enter(keys[K_ENTER]), .key_dir(keys[K_DIR]), .key_locrem(keys[K_LOCREM]),
        .key_run(keys[K_RUN]), .key_stop(keys[K_STOP]), .key_jog(keys[K_JOG]),
        .main_field, .main_show, .sec_field, .sec_show, .menu_group, .focus_value,
        .local_source_indicator, .remote_source_indicator, .fwd_arrow, .rev_arrow,
        .config_state_indicator, .undervoltage_indicator, .running_indicator,
        .run_cmd, .reverse_cmd, .jog_cmd, .speed_ref, .jog_speed
    );
    task automatic report_and_stop();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Zero-wait slave, but the wait is still bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            $display("ERROR t=%0t pready got=%h exp=%h", $time, pready, 1'b1);
            report_and_stop();
        end
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (3) @(posedge pclk);
    endtask : wr
    task automatic t_regs();
        rdchk(CTRL_OFS, CTRL_RST);
        rdchk(LIMIT_OFS, LIMIT_RST);
        chk(jog_speed, JOG_RST);
        apb(1'b0, 8'h30, 32'h0);
        chk(serr, 1'b1);
    endtask : t_regs
    task automatic t_menu();
        op_u.press(K_ENTER);
        chk(main_show, SHOW_GROUP);
        op_u.press(K_UP);
        chk(menu_group, GROUP_LAST);
        rdchk(STATUS_OFS, 32'h0000_0901);
        op_u.press(K_DOWN);
        op_u.press(K_DOWN);
        chk(menu_group, 4'h1);
        op_u.press(K_UP);
        op_u.press(K_ENTER);
        chk(focus_value, 1'b0);
        op_u.press(K_ESC);
        chk(main_show, SHOW_GROUP);
        op_u.press(K_ESC);
        chk(main_show, SHOW_VAR);
    endtask : t_menu
    task automatic t_edit();
        wr(PTAB_OFS, 32'h5);
        wr(LIMIT_OFS, 32'h0006_0003);
        repeat (3) op_u.press(K_ENTER);
        chk(focus_value, 1'b1);
        op_u.press(K_UP);
        op_u.press(K_ESC);
        rdchk(PTAB_OFS, 32'h5);
        chk(focus_value, 1'b0);
        op_u.press(K_ENTER);
        repeat (2) op_u.press(K_UP);
        op_u.press(K_ENTER);
        rdchk(PTAB_OFS, 32'h6);
        op_u.press(K_ENTER);
        repeat (4) op_u.press(K_DOWN);
        op_u.press(K_ENTER);
        rdchk(PTAB_OFS, 32'h3);
        wr(PTAB_OFS, 32'h0001_0005);
        op_u.press(K_ENTER);
        op_u.press(K_DOWN);
        op_u.press(K_ENTER);
        rdchk(PTAB_OFS, 32'h0001_0005);
        // Config-only entry: refused while running, taken once stopped
        wr(PTAB_OFS, 32'h0002_0005);
        op_u.press(K_RUN);
        op_u.press(K_ENTER);
        op_u.press(K_DOWN);
        op_u.press(K_ENTER);
        rdchk(PTAB_OFS, 32'h0002_0005);
        op_u.press(K_STOP);
        op_u.press(K_ENTER);
        op_u.press(K_DOWN);
        op_u.press(K_ENTER);
        rdchk(PTAB_OFS, 32'h0002_0004);
        repeat (2) op_u.press(K_ESC);
        wr(LIMIT_OFS, LIMIT_RST);
    endtask : t_edit
    task automatic t_motor();
        wr(MON_OFS, 32'h2222_1111);
        chk({sec_field, main_field}, 32'h2222_1111);
        op_u.press(K_UP);
        chk(speed_ref > 16'h0000, 1'b1);
        op_u.press(K_DIR);
        chk({reverse_cmd, rev_arrow, fwd_arrow}, 3'h6);
        op_u.press(K_LOCREM);
        chk(remote_source_indicator, 1'b1);
        op_u.press(K_LOCREM);
        op_u.press(K_RUN);
        chk({run_cmd, running_indicator}, 2'h3);
        op_u.press(K_STOP);
        chk(run_cmd, 1'b0);
        // Sources that refuse direction, toggle and run
        wr(CTRL_OFS, 32'h0007_1448);
        chk({config_state_indicator, undervoltage_indicator}, 2'h3);
        op_u.press(K_DIR);
        op_u.press(K_LOCREM);
        op_u.press(K_RUN);
        chk({reverse_cmd, local_source_indicator, run_cmd}, 3'h6);
        wr(CTRL_OFS, CTRL_RST);
    endtask : t_motor
    task automatic t_jog();
        op_u.hold(K_JOG, 1'b1);
        chk(jog_cmd, 1'b1);
        op_u.hold(K_JOG, 1'b0);
        chk(jog_cmd, 1'b0);
        op_u.press(K_RUN);
        op_u.hold(K_JOG, 1'b1);
        chk(jog_cmd, 1'b0);
        op_u.hold(K_JOG, 1'b0);
        op_u.press(K_STOP);
    endtask : t_jog
    task automatic t_fault();
        wr(FAULT_OFS, 32'h0001_0023);
        chk({main_show, main_field}, {SHOW_FAULT, 16'h0023});
        op_u.press(K_ENTER);
        chk(main_show, SHOW_FAULT);
        op_u.press(K_ESC);
        chk({sec_show, sec_field, main_show}, {SHOW_FAULT, 16'h0023, SHOW_VAR});
        wr(FAULT_OFS, 32'h0);
        wr(ALARM_OFS, 32'h0001_0042);
        chk(main_show, SHOW_ALARM);
        op_u.press(K_ENTER);
        chk({sec_show, main_show}, {SHOW_ALARM, SHOW_VAR});
        wr(ALARM_OFS, 32'h0);
        chk(sec_show, SHOW_VAR);
    endtask : t_fault
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_menu();
        t_edit();
        t_motor();
        t_jog();
        t_fault();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("ERROR t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule : keypad_menu_navigator_test

// ---- verification/keypad_operator.sv ----
// Operator model pressing and holding front-panel keys
`timescale 1ns/1ps
module keypad_operator
    import keypad_menu_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Key levels, high while pressed
    output logic [KEY_N-1:0] keys
);
    initial keys = '0;
    // Held five cycles so the synchroniser sees one clean press
    task automatic press(input int k);
        @(posedge pclk);
        keys[k] <= 1'b1;
        repeat (5) @(posedge pclk);
        keys[k] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : press
    task automatic hold(input int k, input logic on);
        @(posedge pclk);
        keys[k] <= on;
        repeat (8) @(posedge pclk);
    endtask : hold
endmodule : keypad_operator
